/* File: src/tmb_device.sv */
// timer_b device end: 16-bit counter with periodic, time-out and capture modes
// assumes config arrives as plain ports; link inputs come from another source
`timescale 1ns/100ps

module tmb_device #(
  parameter int CNT_W = tmb_pkg::CNT_W
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_B,
  input  wire logic                       ENABLE,
  input  wire tmb_pkg::tmb_mode_t         MODE,
  input  wire tmb_pkg::tmb_clock_source_select_t       CLOCK_SOURCE_SELECT,
  input  wire logic                       EDGE_SELECT,
  input  wire logic                       WAVEFORM_OUTPUT_ENABLE,
  input  wire logic                       PORT_OUT_VALUE,
  input  wire logic                       COMPARE_CAPTURE_VALUE_WR,
  input  wire logic [CNT_W-1:0]           COMPARE_CAPTURE_VALUE_WDATA,
  input  wire logic                       CNT_WR,
  input  wire logic [CNT_W-1:0]           CNT_WDATA,
  input  wire logic                       COMPARE_CAPTURE_VALUE_LO_RD,
  input  wire logic                       CNT_RD,
  input  wire logic                       RUN_WR,
  input  wire logic                       RUN_WDATA,
  input  wire logic                       SNAPSHOT_CLR,
  input  wire logic                       WRAP_CLR,
  output logic [CNT_W-1:0]                COUNT_VALUE,
  output logic [CNT_W-1:0]                COMPARE_CAPTURE_VALUE,
  output logic                            SNAPSHOT_FLAG,
  output logic                            WRAP_FLAG,
  output logic                            RUN_STATUS,
  tmb_link_if.device                      link
);

  // ==========================================================================
  // event input synchroniser: three stages, change accepted when 2nd and 3rd agree
  logic [2:0] evt_sync_reg;
  logic       evt_level_reg;
  logic [2:0] cev_sync_reg;
  logic       cev_level_reg;
  logic [2:0] ctc_sync_reg;
  logic       ctc_level_reg;
  logic       evt_rise;
  logic       evt_fall;
  logic       cev_rise;
  logic       ctc_rise;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      evt_sync_reg  <= 3'h0;
      evt_level_reg <= 1'b0;
      cev_sync_reg  <= 3'h0;
      cev_level_reg <= 1'b0;
      ctc_sync_reg  <= 3'h0;
      ctc_level_reg <= 1'b0;
    end else begin
      evt_sync_reg <= {evt_sync_reg[1:0], link.evt_in};
      cev_sync_reg <= {cev_sync_reg[1:0], link.clk_event};
      ctc_sync_reg <= {ctc_sync_reg[1:0], link.companion_timer_clock};
      if (evt_sync_reg[1] == evt_sync_reg[2]) begin
        evt_level_reg <= evt_sync_reg[2];
      end
      if (cev_sync_reg[1] == cev_sync_reg[2]) begin
        cev_level_reg <= cev_sync_reg[2];
      end
      if (ctc_sync_reg[1] == ctc_sync_reg[2]) begin
        ctc_level_reg <= ctc_sync_reg[2];
      end
    end
  end

  // ==========================================================================
  // edge detection on the filtered level
  // shorter pulses are filtered away
  assign evt_rise = (evt_sync_reg[2] == evt_sync_reg[1]) && evt_sync_reg[2] && !evt_level_reg;
  assign evt_fall = (evt_sync_reg[2] == evt_sync_reg[1]) && !evt_sync_reg[2] && evt_level_reg;
  assign cev_rise = (cev_sync_reg[2] == cev_sync_reg[1]) && cev_sync_reg[2] && !cev_level_reg;
  assign ctc_rise = (ctc_sync_reg[2] == ctc_sync_reg[1]) && ctc_sync_reg[2] && !ctc_level_reg;

  logic evt_edge;
  logic evt_other_edge;
  assign evt_edge       = EDGE_SELECT ? evt_fall : evt_rise;
  assign evt_other_edge = EDGE_SELECT ? evt_rise : evt_fall;

  // ==========================================================================
  // clock source selection and tick
  logic [tmb_pkg::PRESCALE_W-1:0] prescale_reg;
  logic                           tick;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prescale_reg <= tmb_pkg::PRESCALE_RESET;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_comb begin
    case (CLOCK_SOURCE_SELECT)
      tmb_pkg::TMB_CLK_DIV1:      tick = 1'b1;
      tmb_pkg::TMB_CLK_DIV2:      tick = prescale_reg[0];
      tmb_pkg::TMB_CLK_COMPANION: tick = ctc_rise;
      tmb_pkg::TMB_CLK_EVENT:     tick = cev_rise;
      default:                    tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // counter, run state and capture
  // one counter, mode-decoded
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] compare_capture_value_reg;
  logic             run_reg;
  logic             at_top;
  logic             at_max;
  logic             snapshot_flag_set;
  logic             wrap_set;
  logic             frozen;

  assign at_max = (cnt_reg == tmb_pkg::MAX_VAL);
  assign at_top = (cnt_reg == compare_capture_value_reg);
  assign frozen = (MODE == tmb_pkg::TMB_TIMEOUT) && !run_reg;

  always_comb begin
    snapshot_flag_set = 1'b0;
    wrap_set = 1'b0;
    if (ENABLE) begin
      case (MODE)
        tmb_pkg::TMB_PERIODIC: begin
          snapshot_flag_set = tick && at_top;
          wrap_set = tick && at_max && !at_top;
        end
        tmb_pkg::TMB_TIMEOUT: begin
          snapshot_flag_set = tick && run_reg && at_top;
          wrap_set = tick && run_reg && at_max && !at_top;
        end
        tmb_pkg::TMB_SNAPSHOT_FLAG_EVENT, tmb_pkg::TMB_SNAPSHOT_FLAG_FREQ: begin
          snapshot_flag_set = evt_edge;
          wrap_set = tick && at_max;
        end
        default: begin
          snapshot_flag_set = 1'b0;
          wrap_set = 1'b0;
        end
      endcase
    end
  end

  // time-out run state; run writes ignored while frozen
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_reg <= 1'b0;
    end else if (!ENABLE) begin
      run_reg <= 1'b0;
    end else if (MODE == tmb_pkg::TMB_TIMEOUT) begin
      // start edge runs, stop edge freezes
      if (!run_reg && evt_edge) begin
        run_reg <= 1'b1;
      end else if (run_reg && evt_other_edge) begin
        run_reg <= 1'b0;
      end else if (RUN_WR && !frozen) begin
        run_reg <= RUN_WDATA;
      end
    end else begin
      run_reg <= 1'b1;
    end
  end

  // count register; software write has priority
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= tmb_pkg::CNT_RESET;
    end else if (CNT_WR) begin
      cnt_reg <= CNT_WDATA;
    end else if (ENABLE) begin
      case (MODE)
        // run to top or wrap at max
        tmb_pkg::TMB_PERIODIC: begin
          if (tick) begin
            cnt_reg <= at_top ? tmb_pkg::BOTTOM_VAL : cnt_reg + 1'b1;
          end
        end
        tmb_pkg::TMB_TIMEOUT: begin
          if (!run_reg && evt_edge) begin
            cnt_reg <= tmb_pkg::BOTTOM_VAL;
          end else if (run_reg && tick && !evt_other_edge) begin
            cnt_reg <= at_top ? tmb_pkg::BOTTOM_VAL : cnt_reg + 1'b1;
          end
        end
        tmb_pkg::TMB_SNAPSHOT_FLAG_FREQ: begin
          if (evt_edge) begin
            cnt_reg <= tmb_pkg::BOTTOM_VAL;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // compare/capture register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      compare_capture_value_reg <= tmb_pkg::COMPARE_CAPTURE_VALUE_RESET;
    end else if (ENABLE && snapshot_flag_set &&
                 (MODE == tmb_pkg::TMB_SNAPSHOT_FLAG_EVENT || MODE == tmb_pkg::TMB_SNAPSHOT_FLAG_FREQ)) begin
      compare_capture_value_reg <= cnt_reg;
    end else if (COMPARE_CAPTURE_VALUE_WR) begin
      compare_capture_value_reg <= COMPARE_CAPTURE_VALUE_WDATA;
    end
  end

  // ==========================================================================
  // flags: set wins over clear
  logic snap_reg;
  logic wrap_reg;
  logic snapshot_flag_mode;
  assign snapshot_flag_mode = (MODE == tmb_pkg::TMB_SNAPSHOT_FLAG_EVENT) || (MODE == tmb_pkg::TMB_SNAPSHOT_FLAG_FREQ);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      snap_reg <= 1'b0;
    end else if (snapshot_flag_set) begin
      snap_reg <= 1'b1;
    end else if (SNAPSHOT_CLR || (COMPARE_CAPTURE_VALUE_LO_RD && snapshot_flag_mode)) begin
      // low byte read clears in capture modes
      snap_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wrap_reg <= 1'b0;
    end else if (wrap_set) begin
      wrap_reg <= 1'b1;
    end else if (WRAP_CLR) begin
      wrap_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // registered outputs; reads have no side effect beyond the capture-mode clear
  logic snap_evt_reg;
  logic wrap_evt_reg;
  logic wave_reg;
  logic wave_oe_reg;
  logic wave_level_reg;

  // waveform toggles at top in periodic mode, a simple square output
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wave_level_reg <= 1'b0;
    end else if (!ENABLE) begin
      wave_level_reg <= 1'b0;
    end else if (snapshot_flag_set && MODE == tmb_pkg::TMB_PERIODIC) begin
      wave_level_reg <= !wave_level_reg;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      snap_evt_reg <= 1'b0;
      wrap_evt_reg <= 1'b0;
      wave_reg     <= 1'b0;
      wave_oe_reg  <= 1'b0;
    end else begin
      snap_evt_reg <= snapshot_flag_set;
      wrap_evt_reg <= wrap_set;
      wave_reg     <= WAVEFORM_OUTPUT_ENABLE ? wave_level_reg : PORT_OUT_VALUE;
      wave_oe_reg  <= 1'b1;
    end
  end

  assign COUNT_VALUE           = cnt_reg;
  assign COMPARE_CAPTURE_VALUE = compare_capture_value_reg;
  assign SNAPSHOT_FLAG         = snap_reg;
  assign WRAP_FLAG             = wrap_reg;
  assign RUN_STATUS            = run_reg;
  assign link.snapshot_event   = snap_evt_reg;
  assign link.wrap_event       = wrap_evt_reg;
  assign link.waveform_pin     = wave_reg;
  assign link.waveform_pin_oe  = wave_oe_reg;

endmodule

/* File: src/tmb_link_if.sv */
// interface joining the timer_b device and its event/clock source
// assumes both ends run on the same system clock
`timescale 1ns/100ps

interface tmb_link_if;
  logic evt_in;
  logic companion_timer_clock;
  logic clk_event;
  logic snapshot_event;
  logic wrap_event;
  logic waveform_pin;
  logic waveform_pin_oe;

  modport device (
    input  evt_in,
    input  companion_timer_clock,
    input  clk_event,
    output snapshot_event,
    output wrap_event,
    output waveform_pin,
    output waveform_pin_oe
  );

  modport source (
    output evt_in,
    output companion_timer_clock,
    output clk_event,
    input  snapshot_event,
    input  wrap_event,
    input  waveform_pin,
    input  waveform_pin_oe
  );
endinterface

/* File: src/tmb_pkg.sv */
// package for the timer_b capture counter: modes, clock selects, reset values
// assumes a single 50 MHz system clock shared by both ends
package tmb_pkg;

  // ==========================================================================
  // counter limits
  localparam int          CNT_W       = 16;
  localparam logic [15:0] BOTTOM_VAL  = 16'h0000;
  localparam logic [15:0] MAX_VAL     = 16'hffff;
  localparam logic [15:0] COMPARE_CAPTURE_VALUE_RESET  = 16'h0000;
  localparam logic [15:0] CNT_RESET   = 16'h0000;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ          = 50;
  localparam int EVT_HOLD_CYCLES  = 2;
  localparam int PRESCALE_W       = 3;

  // ==========================================================================
  // operating modes, eight codes
  typedef enum logic [2:0] {
    TMB_PERIODIC,
    TMB_TIMEOUT,
    TMB_SNAPSHOT_FLAG_EVENT,
    TMB_SNAPSHOT_FLAG_FREQ,
    TMB_SNAPSHOT_FLAG_PW,
    TMB_SNAPSHOT_FLAG_FRQPW,
    TMB_SINGLE,
    TMB_PWM8
  } tmb_mode_t;

  localparam tmb_mode_t MODE_RESET = TMB_PERIODIC;

  // clock source select
  typedef enum logic [1:0] {
    TMB_CLK_DIV1,
    TMB_CLK_DIV2,
    TMB_CLK_COMPANION,
    TMB_CLK_EVENT
  } tmb_clock_source_select_t;

  localparam tmb_clock_source_select_t CLOCK_SOURCE_SELECT_RESET = TMB_CLK_DIV1;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 3'h0;

endpackage

/* File: src/tmb_source.sv */
// event routing and clock source end: drives event and clock inputs of timer_b
// assumes user-side requests are synchronous to CLK
`timescale 1ns/100ps

module tmb_source (
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic EVT_REQ,
  input  wire logic EVT_LEVEL,
  input  wire logic CLK_EVT_REQ,
  input  wire logic COMPANION_TICK,
  output logic      SNAPSHOT_SEEN,
  output logic      WRAP_SEEN,
  output logic      WAVEFORM_LEVEL,
  tmb_link_if.source link
);

  // ==========================================================================
  // pulses stretched past one clock
  logic       evt_reg;
  logic       cev_reg;
  logic       ctc_reg;
  logic [1:0] cev_hold_reg;
  logic [1:0] ctc_hold_reg;
  logic       snap_reg;
  logic       wrap_reg;
  logic       wave_reg;

  // drive a routed event channel level
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      evt_reg <= 1'b0;
    end else if (EVT_REQ) begin
      evt_reg <= EVT_LEVEL;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cev_hold_reg <= 2'h0;
      ctc_hold_reg <= 2'h0;
      cev_reg      <= 1'b0;
      ctc_reg      <= 1'b0;
    end else begin
      cev_hold_reg <= CLK_EVT_REQ ? 2'(tmb_pkg::EVT_HOLD_CYCLES) :
                      (cev_hold_reg != 2'h0 ? cev_hold_reg - 2'h1 : 2'h0);
      ctc_hold_reg <= COMPANION_TICK ? 2'(tmb_pkg::EVT_HOLD_CYCLES) :
                      (ctc_hold_reg != 2'h0 ? ctc_hold_reg - 2'h1 : 2'h0);
      cev_reg      <= CLK_EVT_REQ || (cev_hold_reg > 2'h1);
      ctc_reg      <= COMPANION_TICK || (ctc_hold_reg > 2'h1);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      snap_reg <= 1'b0;
      wrap_reg <= 1'b0;
      wave_reg <= 1'b0;
    end else begin
      snap_reg <= link.snapshot_event;
      wrap_reg <= link.wrap_event;
      wave_reg <= link.waveform_pin_oe ? link.waveform_pin : 1'b0;
    end
  end

  assign link.evt_in                = evt_reg;
  assign link.clk_event             = cev_reg;
  assign link.companion_timer_clock = ctc_reg;
  assign SNAPSHOT_SEEN              = snap_reg;
  assign WRAP_SEEN                  = wrap_reg;
  assign WAVEFORM_LEVEL             = wave_reg;

endmodule

/* File: verif/timer_b_capture_counter_tb.sv */
// testbench: both timer_b ends joined by the link, user sides driven here
// assumes package, link and both design ends compile first
`timescale 1ns/100ps

module timer_b_capture_counter_tb;
  logic                 CLK, RST_B, ENABLE, EDGE_SELECT, WAVEFORM_OUTPUT_ENABLE, PORT_OUT_VALUE;
  logic                 COMPARE_CAPTURE_VALUE_WR, CNT_WR, COMPARE_CAPTURE_VALUE_LO_RD, CNT_RD, RUN_WR, RUN_WDATA, SNAPSHOT_CLR, WRAP_CLR;
  logic                 EVT_REQ, EVT_LEVEL, SNAPSHOT_FLAG, WRAP_FLAG, RUN_STATUS, snap_seen, wrap_seen, wave_lvl;
  logic [15:0]          COMPARE_CAPTURE_VALUE_WDATA, CNT_WDATA, COUNT_VALUE, COMPARE_CAPTURE_VALUE, c;
  tmb_pkg::tmb_mode_t   MODE;
  tmb_pkg::tmb_clock_source_select_t CLOCK_SOURCE_SELECT;
  int                   n_errors, tests_run, i;
  wire [2:0]            fl = {RUN_STATUS, WRAP_FLAG, SNAPSHOT_FLAG};

  // ==========================================================================
  // the two ends and the checker
  tmb_link_if link ();
  tmb_device u_tmb_device (.CLK, .RST_B, .ENABLE, .MODE, .CLOCK_SOURCE_SELECT, .EDGE_SELECT, .WAVEFORM_OUTPUT_ENABLE,
    .PORT_OUT_VALUE, .COMPARE_CAPTURE_VALUE_WR, .COMPARE_CAPTURE_VALUE_WDATA, .CNT_WR, .CNT_WDATA, .COMPARE_CAPTURE_VALUE_LO_RD, .CNT_RD, .RUN_WR, .RUN_WDATA,
    .SNAPSHOT_CLR, .WRAP_CLR, .COUNT_VALUE, .COMPARE_CAPTURE_VALUE, .SNAPSHOT_FLAG, .WRAP_FLAG, .RUN_STATUS,
    .link(link));
  // event-driven clock and companion ticks stay idle: only the divided clocks are exercised
  tmb_source u_tmb_source (.CLK, .RST_B, .EVT_REQ, .EVT_LEVEL, .CLK_EVT_REQ(1'b0), .COMPANION_TICK(1'b0),
    .SNAPSHOT_SEEN(snap_seen), .WRAP_SEEN(wrap_seen), .WAVEFORM_LEVEL(wave_lvl), .link(link));
  tmb_link_assertions u_tmb_link_assertions (.CLK, .RST_B, .ENABLE, .MODE, .CLOCK_SOURCE_SELECT,
    .WAVEFORM_OUTPUT_ENABLE, .PORT_OUT_VALUE, .CNT_WR, .COUNT_VALUE, .COMPARE_CAPTURE_VALUE, .SNAPSHOT_FLAG,
    .WRAP_FLAG, .RUN_STATUS, .snapshot_event(link.snapshot_event), .wrap_event(link.wrap_event),
    .waveform_pin(link.waveform_pin), .waveform_pin_oe(link.waveform_pin_oe));

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] t=%0t %s", $time, m);
    end
  endtask

  // sample just after the edge so the edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic waitf(input int w, input logic v);
    for (i = 0; i < 60 && fl[w] !== v; i++) tick(1);
    if (fl[w] !== v) begin
      n_errors++;
      $display("[FAIL] t=%0t wait timed out", $time);
      report_and_stop();
    end
  endtask

  // counter stopped while mode, top and count change, flags cleared
  task automatic cfg(input tmb_pkg::tmb_mode_t m, input logic [15:0] cp, input logic [15:0] cn);
    @(posedge CLK);
    ENABLE     <= 1'b0;
    MODE       <= m;
    COMPARE_CAPTURE_VALUE_WDATA <= cp;
    CNT_WDATA  <= cn;
    {COMPARE_CAPTURE_VALUE_WR, CNT_WR, SNAPSHOT_CLR, WRAP_CLR} <= 4'hf;
    @(posedge CLK);
    {COMPARE_CAPTURE_VALUE_WR, CNT_WR, SNAPSHOT_CLR, WRAP_CLR} <= 4'h0;
    ENABLE <= 1'b1;
    tick(1);
  endtask

  // level is held for many cycles, well past the synchroniser
  task automatic evt(input logic v);
    @(posedge CLK);
    EVT_REQ   <= 1'b1;
    EVT_LEVEL <= v;
    @(posedge CLK);
    EVT_REQ <= 1'b0;
    tick(6);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    chk(COUNT_VALUE === tmb_pkg::CNT_RESET && COMPARE_CAPTURE_VALUE === tmb_pkg::COMPARE_CAPTURE_VALUE_RESET, "reset values");
    chk(fl === 3'h0, "flags after reset");
    $display("test reset done");
  endtask

  task automatic t_periodic;
    @(posedge CLK) WAVEFORM_OUTPUT_ENABLE <= 1'b1;
    cfg(tmb_pkg::TMB_PERIODIC, 16'h0002, 16'h0000);
    waitf(0, 1'b1);
    chk(COUNT_VALUE === 16'h0000, "periodic restart");
    // the event pulse rises with the flag and stands for this one cycle only
    chk(link.snapshot_event === 1'b1 && link.waveform_pin_oe === 1'b1, "snapshot event or pin enable");
    tick(1);
    chk(snap_seen === 1'b1, "event not seen by source");
    cfg(tmb_pkg::TMB_PERIODIC, 16'h0100, 16'h0000);
    @(posedge CLK) CLOCK_SOURCE_SELECT <= tmb_pkg::TMB_CLK_DIV2;
    tick(20);
    chk(COUNT_VALUE >= 16'h000a && COUNT_VALUE <= 16'h000d, "half rate count");
    @(posedge CLK) CLOCK_SOURCE_SELECT <= tmb_pkg::TMB_CLK_DIV1;
    $display("test periodic done");
  endtask

  task automatic t_wrap;
    cfg(tmb_pkg::TMB_PERIODIC, 16'h0005, 16'hfffd);
    waitf(1, 1'b1);
    chk(COUNT_VALUE < 16'h0002 && SNAPSHOT_FLAG === 1'b0, "wrap past lowered top");
    chk(link.wrap_event === 1'b1, "wrap event missing");
    tick(1);
    chk(wrap_seen === 1'b1, "wrap event not seen by source");
    @(posedge CLK);
    WAVEFORM_OUTPUT_ENABLE <= 1'b0;
    PORT_OUT_VALUE         <= 1'b1;
    tick(3);
    chk(link.waveform_pin === 1'b1 && wave_lvl === 1'b1, "port value on pin");
    $display("test wrap done");
  endtask

  task automatic t_capture;
    for (int e = 0; e < 2; e++) begin
      @(posedge CLK) EDGE_SELECT <= e[0];
      cfg(tmb_pkg::TMB_SNAPSHOT_FLAG_EVENT, 16'h0000, 16'hfff0);
      evt(!e[0]);
      c = COUNT_VALUE - COMPARE_CAPTURE_VALUE;
      chk(SNAPSHOT_FLAG === 1'b1 && c > 16'h0000 && c < 16'h0008, "capture of count");
      @(posedge CLK) COMPARE_CAPTURE_VALUE_LO_RD <= 1'b1;
      @(posedge CLK) COMPARE_CAPTURE_VALUE_LO_RD <= 1'b0;
      tick(8);
      chk(SNAPSHOT_FLAG === 1'b0 && WRAP_FLAG === 1'b1, "read clear or free-run wrap");
    end
    $display("test capture done");
  endtask

  task automatic t_freq;
    @(posedge CLK) EDGE_SELECT <= 1'b0;
    cfg(tmb_pkg::TMB_SNAPSHOT_FLAG_FREQ, 16'h0000, 16'h0000);
    evt(1'b1);
    evt(1'b0);
    tick(20);
    evt(1'b1);
    chk(COMPARE_CAPTURE_VALUE >= 16'h0022 && COMPARE_CAPTURE_VALUE <= 16'h0026, "period capture");
    chk(COUNT_VALUE < 16'h0008 && SNAPSHOT_FLAG === 1'b1, "restart after capture");
    $display("test frequency done");
  endtask

  task automatic t_timeout;
    cfg(tmb_pkg::TMB_TIMEOUT, 16'h0010, 16'h0000);
    evt(1'b0);
    evt(1'b1);
    chk(RUN_STATUS === 1'b1, "start edge");
    waitf(0, 1'b1);
    evt(1'b0);
    c = COUNT_VALUE;
    @(posedge CLK) {RUN_WR, RUN_WDATA, CNT_RD, COMPARE_CAPTURE_VALUE_LO_RD} <= 4'hf;
    @(posedge CLK) {RUN_WR, RUN_WDATA, CNT_RD, COMPARE_CAPTURE_VALUE_LO_RD} <= 4'h0;
    tick(4);
    chk(RUN_STATUS === 1'b0 && COUNT_VALUE === c && SNAPSHOT_FLAG === 1'b1, "frozen state disturbed");
    @(posedge CLK) EDGE_SELECT <= 1'b1;
    evt(1'b1);
    chk(RUN_STATUS === 1'b0, "rising is stop edge");
    evt(1'b0);
    chk(RUN_STATUS === 1'b1 && COUNT_VALUE < 16'h0008, "falling starts count");
    $display("test timeout done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock and main sequence
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  initial begin
    {RST_B, ENABLE, EDGE_SELECT, WAVEFORM_OUTPUT_ENABLE, PORT_OUT_VALUE, COMPARE_CAPTURE_VALUE_WR, CNT_WR, COMPARE_CAPTURE_VALUE_LO_RD} = '0;
    {CNT_RD, RUN_WR, RUN_WDATA, SNAPSHOT_CLR, WRAP_CLR, EVT_REQ, EVT_LEVEL, COMPARE_CAPTURE_VALUE_WDATA, CNT_WDATA} = '0;
    MODE                = tmb_pkg::TMB_PERIODIC;
    CLOCK_SOURCE_SELECT = tmb_pkg::TMB_CLK_DIV1;
    n_errors            = 0;
    tests_run           = 0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    tick(1);
    t_reset();
    t_periodic();
    t_wrap();
    t_capture();
    t_freq();
    t_timeout();
    // second reset while the counter runs
    @(posedge CLK) RST_B <= 1'b0;
    tick(2);
    @(posedge CLK) RST_B <= 1'b1;
    tick(1);
    t_reset();
    report_and_stop();
  end
endmodule

/* File: verif/tmb_link_assertions.sv */
// checker: timer_b counter, flag and waveform relations beside the link
// assumes one clock domain; instantiated in the bench, no bind
`timescale 1ns/100ps

module tmb_link_assertions (
  input wire logic                 CLK,
  input wire logic                 RST_B,
  input wire logic                 ENABLE,
  input wire tmb_pkg::tmb_mode_t   MODE,
  input wire tmb_pkg::tmb_clock_source_select_t CLOCK_SOURCE_SELECT,
  input wire logic                 WAVEFORM_OUTPUT_ENABLE,
  input wire logic                 PORT_OUT_VALUE,
  input wire logic                 CNT_WR,
  input wire logic [15:0]          COUNT_VALUE,
  input wire logic [15:0]          COMPARE_CAPTURE_VALUE,
  input wire logic                 SNAPSHOT_FLAG,
  input wire logic                 WRAP_FLAG,
  input wire logic                 RUN_STATUS,
  input wire logic                 snapshot_event,
  input wire logic                 wrap_event,
  input wire logic                 waveform_pin,
  input wire logic                 waveform_pin_oe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // ==========================================================================
  // helpers: a tick every cycle with no count write in the way
  wire run1 = ENABLE && !CNT_WR && CLOCK_SOURCE_SELECT == tmb_pkg::TMB_CLK_DIV1;
  wire per  = run1 && MODE == tmb_pkg::TMB_PERIODIC;
  wire cap  = run1 && MODE == tmb_pkg::TMB_SNAPSHOT_FLAG_EVENT;
  wire maxd = COUNT_VALUE == tmb_pkg::MAX_VAL;

  // ==========================================================================
  // assertions
  // flag and event pulse are launched by the same edge, so they are seen together
  snap_event_a: assert property ($rose(SNAPSHOT_FLAG) |-> snapshot_event)
    else $error("snapshot flag set without its event");
  wrap_event_a: assert property ($rose(WRAP_FLAG) |-> wrap_event)
    else $error("wrap flag set without its event");
  top_restart_a: assert property (per && COUNT_VALUE == COMPARE_CAPTURE_VALUE
    |=> COUNT_VALUE == 16'h0000 && SNAPSHOT_FLAG) else $error("periodic count did not restart at top");
  max_wrap_a: assert property (per && maxd && COMPARE_CAPTURE_VALUE != tmb_pkg::MAX_VAL
    |=> COUNT_VALUE == 16'h0000 && WRAP_FLAG) else $error("count did not wrap at maximum");
  free_run_a: assert property (cap && !maxd
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001) else $error("capture mode count not free running");
  cap_wrap_a: assert property (cap && maxd |=> WRAP_FLAG && COUNT_VALUE == 16'h0000)
    else $error("capture mode wrap missing");
  frozen_hold_a: assert property ((MODE == tmb_pkg::TMB_TIMEOUT && !RUN_STATUS && !CNT_WR) ##1 !RUN_STATUS
    |-> $stable(COUNT_VALUE)) else $error("frozen count moved");
  pin_port_a: assert property (!WAVEFORM_OUTPUT_ENABLE |=> waveform_pin == $past(PORT_OUT_VALUE))
    else $error("pin does not follow port value");
  pin_enable_a: assert property (WAVEFORM_OUTPUT_ENABLE |=> waveform_pin_oe)
    else $error("pin not driven while waveform enabled");

  periodic_top_c: cover property (per && COUNT_VALUE == COMPARE_CAPTURE_VALUE);
  timeout_run_c: cover property ($rose(RUN_STATUS));
  wrap_seen_c: cover property (wrap_event);
endmodule
